/* soft_reset_clock_gate_ctrl.sv */
// block reset hold and block clock stop control registers
`timescale 1ns/10ps
// How it works
// (RULE1) bias calibration hold bit 8 keeps bias calibration logic in reset while set
// (RULE2) converter hold bit 7 keeps the time converter logic in reset while set
// (RULE3) digital loop hold bit 6 keeps the whole digital loop in reset
// (RULE4) bit 5 holds the inverted input activity watch in reset
// (RULE5) bit 4 holds the true input activity watch in reset
// (RULE6) bit 3 holds the crystal reference signal loss watch in reset
// (RULE7) bit 2 holds the inverted input signal loss watch in reset
// (RULE8) bit 1 holds the true input signal loss watch in reset
// (RULE9) bit 0 holds the fuse memory logic in reset
// (RULE10) any set clock stop bit stops the clock of its named block
// (RULE11) master stop bit 11 stops all clocks without own bit, bus clock included
// (RULE12) once master stop is set, no register access until power cycle
// (RULE13) stop bit 5 stops the inverted input activity watch clock
// (RULE14) stop bit 4 stops the true input activity watch clock
// (RULE15) stop bit 3 stops the crystal reference signal loss watch clock
// (RULE16) stop bit 2 stops the inverted input signal loss watch clock
// (RULE17) stop bit 1 stops the true input signal loss watch clock
// (RULE18) after reset all hold and stop bits are zero; read-only reserved read zero
// (RULE19) writable reserved bits store writes and steer nothing
module soft_reset_clock_gate_ctrl (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            reset,
  // register port from the serial port decoder
  input  wire logic                            reg_write,
  input  wire logic                            reg_read,
  input  wire logic [clock_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [clock_ctrl_pkg::REG_W-1:0]  reg_wdata,
  output logic      [clock_ctrl_pkg::REG_W-1:0]  reg_rdata,
  output logic                                 reg_rvalid,
  output logic                                 reg_error,
  output logic                                 bus_locked,
  // reset holds to the logic blocks
  output logic                                 bias_calibration_hold,
  output logic                                 time_converter_hold,
  output logic                                 digital_loop_hold,
  output logic                                 activity_watch_b_hold,
  output logic                                 activity_watch_a_hold,
  output logic                                 signal_loss_watch_c_hold,
  output logic                                 signal_loss_watch_b_hold,
  output logic                                 signal_loss_watch_a_hold,
  output logic                                 fuse_memory_hold,
  // clock stops to the gate cells
  output logic                                 master_logic_clock_stop,
  output logic                                 activity_watch_b_stop,
  output logic                                 activity_watch_a_stop,
  output logic                                 signal_loss_watch_c_stop,
  output logic                                 signal_loss_watch_b_stop,
  output logic                                 signal_loss_watch_a_stop
);
  import clock_ctrl_pkg::*;

  logic [REG_W-1:0] hold_q;
  logic [REG_W-1:0] hold_d;
  logic [REG_W-1:0] stop_q;
  logic [REG_W-1:0] stop_d;
  logic             lock_q;
  logic             lock_d;
  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;
  logic             rvalid_q;
  logic             rvalid_d;
  logic             error_q;
  logic             error_d;
  logic             hit_hold;
  logic             hit_stop;

  assign hit_hold = (reg_addr == BLOCK_RESET_HOLD_OFS);
  assign hit_stop = (reg_addr == BLOCK_CLOCK_STOP_OFS);

  // register state
  always_comb begin
    hold_d   = hold_q;
    stop_d   = stop_q;
    lock_d   = lock_q;
    rdata_d  = RDATA_RST;
    rvalid_d = 1'b0;
    error_d  = 1'b0;
    // the bus clock is gone once locked, so the port is dead until power-up reset
    if (!lock_q) begin // see (RULE12)
      if (reg_write) begin
        if (hit_hold) begin
          hold_d = reg_wdata & BLOCK_RESET_HOLD_WMASK; // see (RULE18) (RULE19)
        end else if (hit_stop) begin
          stop_d = reg_wdata & BLOCK_CLOCK_STOP_WMASK; // see (RULE18) (RULE19)
          lock_d = reg_wdata[MASTER_LOGIC_CLOCK_STOP_BIT]; // see (RULE11) (RULE12)
        end else begin
          error_d = 1'b1;
        end
      end else if (reg_read) begin
        rvalid_d = 1'b1;
        if (hit_hold) begin
          rdata_d = hold_q;
        end else if (hit_stop) begin
          rdata_d = stop_q;
        end else begin
          error_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q   <= BLOCK_RESET_HOLD_RST; // see (RULE18)
      stop_q   <= BLOCK_CLOCK_STOP_RST; // see (RULE18)
      lock_q   <= 1'b0;
      rdata_q  <= RDATA_RST;
      rvalid_q <= 1'b0;
      error_q  <= 1'b0;
    end else begin
      hold_q   <= hold_d;
      stop_q   <= stop_d;
      lock_q   <= lock_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      error_q  <= error_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign reg_error  = error_q;
  assign bus_locked = lock_q; // see (RULE12)

  // reset holds straight from stored bits; bit 11 is spare storage only
  assign bias_calibration_hold    = hold_q[BIAS_CALIBRATION_HOLD_BIT];    // see (RULE1)
  assign time_converter_hold      = hold_q[TIME_CONVERTER_HOLD_BIT];      // see (RULE2)
  assign digital_loop_hold        = hold_q[DIGITAL_LOOP_HOLD_BIT];        // see (RULE3)
  assign activity_watch_b_hold    = hold_q[ACTIVITY_WATCH_B_HOLD_BIT];    // see (RULE4)
  assign activity_watch_a_hold    = hold_q[ACTIVITY_WATCH_A_HOLD_BIT];    // see (RULE5)
  assign signal_loss_watch_c_hold = hold_q[SIGNAL_LOSS_WATCH_C_HOLD_BIT]; // see (RULE6)
  assign signal_loss_watch_b_hold = hold_q[SIGNAL_LOSS_WATCH_B_HOLD_BIT]; // see (RULE7)
  assign signal_loss_watch_a_hold = hold_q[SIGNAL_LOSS_WATCH_A_HOLD_BIT]; // see (RULE8)
  assign fuse_memory_hold         = hold_q[FUSE_MEMORY_HOLD_BIT];         // see (RULE9)

  // clock stops; spare stored bits 8, 6 and 0 drive nothing
  assign master_logic_clock_stop  = stop_q[MASTER_LOGIC_CLOCK_STOP_BIT];  // see (RULE10) (RULE11)
  assign activity_watch_b_stop    = stop_q[ACTIVITY_WATCH_B_STOP_BIT];    // see (RULE13)
  assign activity_watch_a_stop    = stop_q[ACTIVITY_WATCH_A_STOP_BIT];    // see (RULE14)
  assign signal_loss_watch_c_stop = stop_q[SIGNAL_LOSS_WATCH_C_STOP_BIT]; // see (RULE15)
  assign signal_loss_watch_b_stop = stop_q[SIGNAL_LOSS_WATCH_B_STOP_BIT]; // see (RULE16)
  assign signal_loss_watch_a_stop = stop_q[SIGNAL_LOSS_WATCH_A_STOP_BIT]; // see (RULE17)

endmodule // soft_reset_clock_gate_ctrl

/* clock_ctrl_pkg.sv */
// constants for the block reset hold and block clock stop registers
package clock_ctrl_pkg;

  localparam int unsigned REG_W  = 16;
  localparam int unsigned ADDR_W = 8;

  // register offsets on the internal register port
  localparam logic [7:0] BLOCK_RESET_HOLD_OFS = 8'h00;
  localparam logic [7:0] BLOCK_CLOCK_STOP_OFS = 8'h01;

  // block_reset_hold field positions
  localparam int unsigned BIAS_CALIBRATION_HOLD_BIT    = 8;
  localparam int unsigned TIME_CONVERTER_HOLD_BIT      = 7;
  localparam int unsigned DIGITAL_LOOP_HOLD_BIT        = 6;
  localparam int unsigned ACTIVITY_WATCH_B_HOLD_BIT    = 5;
  localparam int unsigned ACTIVITY_WATCH_A_HOLD_BIT    = 4;
  localparam int unsigned SIGNAL_LOSS_WATCH_C_HOLD_BIT = 3;
  localparam int unsigned SIGNAL_LOSS_WATCH_B_HOLD_BIT = 2;
  localparam int unsigned SIGNAL_LOSS_WATCH_A_HOLD_BIT = 1;
  localparam int unsigned FUSE_MEMORY_HOLD_BIT         = 0;

  // block_clock_stop field positions
  localparam int unsigned MASTER_LOGIC_CLOCK_STOP_BIT  = 11;
  localparam int unsigned ACTIVITY_WATCH_B_STOP_BIT    = 5;
  localparam int unsigned ACTIVITY_WATCH_A_STOP_BIT    = 4;
  localparam int unsigned SIGNAL_LOSS_WATCH_C_STOP_BIT = 3;
  localparam int unsigned SIGNAL_LOSS_WATCH_B_STOP_BIT = 2;
  localparam int unsigned SIGNAL_LOSS_WATCH_A_STOP_BIT = 1;

  // bits that store a write; all others read as zero
  localparam logic [15:0] BLOCK_RESET_HOLD_WMASK = 16'h09FF;
  localparam logic [15:0] BLOCK_CLOCK_STOP_WMASK = 16'h097F;

  // values after reset
  localparam logic [15:0] BLOCK_RESET_HOLD_RST = 16'h0000;
  localparam logic [15:0] BLOCK_CLOCK_STOP_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST            = 16'h0000;

endpackage

/* soft_reset_clock_gate_ctrl_sva.sv */
// checker for the block reset hold and clock stop registers
`timescale 1ns/10ps
module soft_reset_clock_gate_ctrl_chk (
  // watched ports
  input wire logic        clk, reset, reg_write, reg_read, reg_rvalid, reg_error,
  input wire logic        bus_locked, bias_calibration_hold, fuse_memory_hold,
  input wire logic        master_logic_clock_stop, signal_loss_watch_a_stop,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  wire wr = reg_write && !bus_locked;
  wire rdok = reg_read && !reg_write && !bus_locked;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  bias_hold_a: assert property (wr && reg_addr == 8'h00
    |=> bias_calibration_hold == $past(reg_wdata[8])) else $error("bias hold wrong");
  fuse_hold_a: assert property (wr && reg_addr == 8'h00
    |=> fuse_memory_hold == $past(reg_wdata[0])) else $error("fuse hold wrong");
  master_stop_a: assert property (wr && reg_addr == 8'h01
    |=> master_logic_clock_stop == $past(reg_wdata[11])) else $error("master stop wrong");
  loss_a_stop_a: assert property (wr && reg_addr == 8'h01
    |=> signal_loss_watch_a_stop == $past(reg_wdata[1])) else $error("loss stop wrong");
  lock_holds_a: assert property (bus_locked |=> bus_locked && !reg_rvalid
    && $stable(bias_calibration_hold)) else $error("locked port still active");
  read_answer_a: assert property (rdok && reg_addr == 8'h00 |=> reg_rvalid
    && reg_rdata[15:12] == 4'h0 && reg_rdata[10:9] == 2'h0) else $error("read answer wrong");
  no_answer_a: assert property (!rdok |=> !reg_rvalid)
    else $error("spurious read answer");
  unmapped_a: assert property ((wr || rdok) && reg_addr > 8'h01 |=> reg_error)
    else $error("unmapped access not flagged");
endmodule // soft_reset_clock_gate_ctrl_chk
bind soft_reset_clock_gate_ctrl soft_reset_clock_gate_ctrl_chk i_chk (.*);

/* soft_reset_clock_gate_ctrl_tb.sv */
// self-checking bench for the block reset hold and clock stop registers
`timescale 1ns/10ps
module soft_reset_clock_gate_ctrl_tb;
  import clock_ctrl_pkg::*;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic reg_rvalid, reg_error, bus_locked, master_logic_clock_stop, time_converter_hold;
  logic bias_calibration_hold, digital_loop_hold, activity_watch_b_hold, activity_watch_a_hold;
  logic signal_loss_watch_c_hold, signal_loss_watch_b_hold, signal_loss_watch_a_hold;
  logic fuse_memory_hold, activity_watch_b_stop, activity_watch_a_stop;
  logic signal_loss_watch_c_stop, signal_loss_watch_b_stop, signal_loss_watch_a_stop;
  int bad_count = 0, compares = 0;
  wire [8:0] holds = {bias_calibration_hold, time_converter_hold, digital_loop_hold,
    activity_watch_b_hold, activity_watch_a_hold, signal_loss_watch_c_hold,
    signal_loss_watch_b_hold, signal_loss_watch_a_hold, fuse_memory_hold};
  wire [4:0] stops = {activity_watch_b_stop, activity_watch_a_stop, signal_loss_watch_c_stop,
    signal_loss_watch_b_stop, signal_loss_watch_a_stop};
  soft_reset_clock_gate_ctrl i_dut (.*);
  always #20 clk = ~clk;
  task automatic test_done;
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 reg_write = 1'b0;
    // idle cycle so a following call never re-raises the strobe in this step
    @(posedge clk);
    #1;
  endtask
  // error expected on every answered read outside the two offsets
  task automatic rd(logic [7:0] a, logic [15:0] e, logic v);
    {reg_read, reg_addr} = {1'b1, a};
    @(posedge clk);
    #1 reg_read = 1'b0;
    chk("reg_rvalid", {15'h0, v}, {15'h0, reg_rvalid});
    chk("reg_error", {15'h0, v && a > 8'h01}, {15'h0, reg_error});
    chk("reg_rdata", e, reg_rdata);
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset_values;
    rd(BLOCK_RESET_HOLD_OFS, 16'h0000, 1'b1);
    rd(BLOCK_CLOCK_STOP_OFS, 16'h0000, 1'b1);
    rd(8'h05, 16'h0000, 1'b1);
    wr(8'h07, 16'hFFFF);
    rd(BLOCK_RESET_HOLD_OFS, 16'h0000, 1'b1);
  endtask
  task automatic t_hold_bits;
    for (int i = 0; i < 9; i++) begin
      wr(BLOCK_RESET_HOLD_OFS, 16'h0001 << i);
      chk("holds", 16'h0001 << i, 16'(holds));
    end
    wr(BLOCK_RESET_HOLD_OFS, 16'hFFFF);
    rd(BLOCK_RESET_HOLD_OFS, 16'h09FF, 1'b1);
    chk("holds", 16'h01FF, 16'(holds));
  endtask
  task automatic t_stop_bits;
    for (int i = 1; i < 6; i++) begin
      wr(BLOCK_CLOCK_STOP_OFS, 16'h0001 << i);
      chk("stops", 16'h0001 << (i - 1), 16'(stops));
    end
    wr(BLOCK_CLOCK_STOP_OFS, 16'hF7FF);
    rd(BLOCK_CLOCK_STOP_OFS, 16'h017F, 1'b1);
    chk("master", 16'h0000, 16'(master_logic_clock_stop));
  endtask
  task automatic t_lock;
    wr(BLOCK_CLOCK_STOP_OFS, 16'h0800);
    chk("master lock", 16'h0003, {14'h0, master_logic_clock_stop, bus_locked});
    wr(BLOCK_RESET_HOLD_OFS, 16'h0001);
    rd(BLOCK_RESET_HOLD_OFS, 16'h0000, 1'b0);
    chk("holds", 16'h01FF, 16'(holds));
  endtask
  task automatic t_rereset;
    reset = 1'b1;
    @(posedge clk);
    #1 reset = 1'b0;
    chk("all", 16'h0000, {holds, stops, bus_locked, master_logic_clock_stop});
    rd(BLOCK_CLOCK_STOP_OFS, 16'h0000, 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    t_reset_values;
    t_hold_bits;
    t_stop_bits;
    t_lock;
    t_rereset;
    test_done;
  end
  initial begin
    #100000;
    bad_count++;
    test_done;
  end
endmodule // soft_reset_clock_gate_ctrl_tb
